/* File: common/sctrb_pkg.sv */
package sctrb_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] ADDR_VCO_COARSE_CAL  = 6'h25;
   localparam logic [5:0] ADDR_SYNTH_CAL_CTRL  = 6'h26;
   localparam logic [5:0] ADDR_RC_OSC_CFG_HI   = 6'h27;
   localparam logic [5:0] ADDR_RC_OSC_CFG_LO   = 6'h28;
   localparam logic [5:0] ADDR_SYNTH_TEST      = 6'h29;
   localparam logic [5:0] ADDR_PRODUCTION_TRIM = 6'h2A;
   localparam logic [5:0] ADDR_GAIN_CTRL_TEST  = 6'h2B;
   localparam logic [5:0] ADDR_ANALOG_TRIM_A   = 6'h2C;
   localparam logic [5:0] ADDR_ANALOG_TRIM_B   = 6'h2D;
   localparam logic [5:0] ADDR_ANALOG_TRIM_C   = 6'h2E;

   // ----------------------------------------------------------------
   // reset values and field masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_VCO_COARSE_CAL  = 8'h20;
   localparam logic [7:0] RST_SYNTH_CAL_CTRL  = 8'h0D;
   localparam logic [7:0] RST_RC_OSC_CFG_HI   = 8'h41;
   localparam logic [7:0] RST_RC_OSC_CFG_LO   = 8'h00;
   localparam logic [7:0] RST_SYNTH_TEST      = 8'h59;
   localparam logic [7:0] RST_PRODUCTION_TRIM = 8'h7F;
   localparam logic [7:0] RST_GAIN_CTRL_TEST  = 8'h3F;
   localparam logic [7:0] RST_ANALOG_TRIM_A   = 8'h88;
   localparam logic [7:0] RST_ANALOG_TRIM_B   = 8'h31;
   localparam logic [7:0] RST_ANALOG_TRIM_C   = 8'h0B;
   localparam logic [7:0] MASK_6BIT           = 8'h3F;
   localparam logic [7:0] MASK_7BIT           = 8'h7F;
   localparam logic [7:0] MASK_8BIT           = 8'hFF;
   localparam logic [7:0] READ_ZERO           = 8'h00;

   // wake values seen by the analog side when the converter is kept on
   localparam logic [7:0] KEEP_ANALOG_TRIM_A  = 8'h81;
   localparam logic [7:0] KEEP_ANALOG_TRIM_B  = 8'h35;

   localparam int         VCO_SEL_CAL_BIT     = 1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_AWAKE = 2'b01,
      ST_SLEEP = 2'b10
   } sctrb_state_t;

   typedef struct packed
   {
      logic [7:0] vco_coarse_cal;
      logic [7:0] synth_cal_ctrl;
      logic [7:0] rc_osc_cfg_hi;
      logic [7:0] rc_osc_cfg_lo;
      logic [7:0] synth_test;
      logic [7:0] production_trim;
      logic [7:0] gain_ctrl_test;
      logic [7:0] analog_trim_a;
      logic [7:0] analog_trim_b;
      logic [7:0] analog_trim_c;
      logic       vco_select_cal_enable;
   } sctrb_cfg_t;

endpackage

/* File: rtl/sctrb_reg_bank.sv */
`timescale 1ns/1ns
module sctrb_reg_bank
#(
   parameter int ADDR_W = 6
)
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic [ADDR_W-1:0]       reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   input  wire logic                    sleep_mode,
   input  wire logic                    converter_keep_setting,
   output sctrb_pkg::sctrb_cfg_t        cfg_out
);
   import sctrb_pkg::*;

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if (ADDR_W != 6)
   begin : g_bad_addr
      $error("sctrb_reg_bank: ADDR_W must be 6");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sctrb_state_t state_q, state_d;
   logic [7:0]   vco_coarse_q, vco_coarse_d;
   logic [7:0]   cal_ctrl_q, cal_ctrl_d;
   logic [7:0]   rc_hi_q, rc_hi_d;
   logic [7:0]   rc_lo_q, rc_lo_d;
   logic [7:0]   synth_test_q, synth_test_d;
   logic [7:0]   prod_trim_q, prod_trim_d;
   logic [7:0]   gain_test_q, gain_test_d;
   logic [7:0]   trim_a_q, trim_a_d;
   logic [7:0]   trim_b_q, trim_b_d;
   logic [7:0]   trim_c_q, trim_c_d;
   logic         keep_a_q, keep_a_d;
   logic         keep_b_q, keep_b_d;
   logic [7:0]   rdata_q, rdata_d;
   logic         wake;
   logic         wr_ok;

   // sleep tracking: wake is the cycle sleep_mode drops
   always_comb
   begin
      state_d = state_q;
      wake    = 1'b0;
      case (state_q)
         ST_AWAKE:
         begin
            if (sleep_mode)
            begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (!sleep_mode)
            begin
               state_d = ST_AWAKE;
               wake    = 1'b1;
            end
         end
         default:
         begin
            state_d = ST_AWAKE;
         end
      endcase
   end

   // writes are dropped while asleep
   assign wr_ok = reg_wr && (state_q == ST_AWAKE) && !sleep_mode;

   // next register values
   always_comb
   begin
      vco_coarse_d = vco_coarse_q;
      cal_ctrl_d   = cal_ctrl_q;
      rc_hi_d      = rc_hi_q;
      rc_lo_d      = rc_lo_q;
      synth_test_d = synth_test_q;
      prod_trim_d  = prod_trim_q;
      gain_test_d  = gain_test_q;
      trim_a_d     = trim_a_q;
      trim_b_d     = trim_b_q;
      trim_c_d     = trim_c_q;
      keep_a_d     = keep_a_q;
      keep_b_d     = keep_b_q;
      if (state_q == ST_SLEEP)
      begin
         // volatile bank held at its defaults while asleep
         synth_test_d = RST_SYNTH_TEST;
         prod_trim_d  = RST_PRODUCTION_TRIM;
         gain_test_d  = RST_GAIN_CTRL_TEST;
         trim_a_d     = RST_ANALOG_TRIM_A;
         trim_b_d     = RST_ANALOG_TRIM_B;
         trim_c_d     = RST_ANALOG_TRIM_C;
         keep_a_d     = 1'b0;
         keep_b_d     = 1'b0;
         if (wake)
         begin
            keep_a_d = converter_keep_setting;
            keep_b_d = converter_keep_setting;
         end
      end
      else if (wr_ok)
      begin
         if (reg_addr == ADDR_VCO_COARSE_CAL)
         begin
            vco_coarse_d = reg_wdata & MASK_6BIT;
         end
         else if (reg_addr == ADDR_SYNTH_CAL_CTRL)
         begin
            cal_ctrl_d = reg_wdata & MASK_7BIT;
         end
         else if (reg_addr == ADDR_RC_OSC_CFG_HI)
         begin
            rc_hi_d = reg_wdata & MASK_7BIT;
         end
         else if (reg_addr == ADDR_RC_OSC_CFG_LO)
         begin
            rc_lo_d = reg_wdata & MASK_7BIT;
         end
         else if (reg_addr == ADDR_SYNTH_TEST)
         begin
            synth_test_d = reg_wdata;
         end
         else if (reg_addr == ADDR_PRODUCTION_TRIM)
         begin
            prod_trim_d = reg_wdata;
         end
         else if (reg_addr == ADDR_GAIN_CTRL_TEST)
         begin
            gain_test_d = reg_wdata;
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_A)
         begin
            trim_a_d = reg_wdata;
            keep_a_d = 1'b0;                         // host value replaces forced one
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_B)
         begin
            trim_b_d = reg_wdata;
            keep_b_d = 1'b0;
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_C)
         begin
            trim_c_d = reg_wdata & MASK_8BIT;
         end
      end
   end

   // read mux, unmapped addresses read zero
   always_comb
   begin
      rdata_d = rdata_q;
      if (reg_rd)
      begin
         if (reg_addr == ADDR_VCO_COARSE_CAL)
         begin
            rdata_d = vco_coarse_q;
         end
         else if (reg_addr == ADDR_SYNTH_CAL_CTRL)
         begin
            rdata_d = cal_ctrl_q;
         end
         else if (reg_addr == ADDR_RC_OSC_CFG_HI)
         begin
            rdata_d = rc_hi_q;
         end
         else if (reg_addr == ADDR_RC_OSC_CFG_LO)
         begin
            rdata_d = rc_lo_q;
         end
         else if (reg_addr == ADDR_SYNTH_TEST)
         begin
            rdata_d = synth_test_q;
         end
         else if (reg_addr == ADDR_PRODUCTION_TRIM)
         begin
            rdata_d = prod_trim_q;
         end
         else if (reg_addr == ADDR_GAIN_CTRL_TEST)
         begin
            rdata_d = gain_test_q;
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_A)
         begin
            rdata_d = trim_a_q;
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_B)
         begin
            rdata_d = trim_b_q;
         end
         else if (reg_addr == ADDR_ANALOG_TRIM_C)
         begin
            rdata_d = trim_c_q;
         end
         else
         begin
            rdata_d = READ_ZERO;
         end
      end
   end

   // registers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q      <= ST_AWAKE;
         vco_coarse_q <= RST_VCO_COARSE_CAL;
         cal_ctrl_q   <= RST_SYNTH_CAL_CTRL;
         rc_hi_q      <= RST_RC_OSC_CFG_HI;
         rc_lo_q      <= RST_RC_OSC_CFG_LO;
         synth_test_q <= RST_SYNTH_TEST;
         prod_trim_q  <= RST_PRODUCTION_TRIM;
         gain_test_q  <= RST_GAIN_CTRL_TEST;
         trim_a_q     <= RST_ANALOG_TRIM_A;
         trim_b_q     <= RST_ANALOG_TRIM_B;
         trim_c_q     <= RST_ANALOG_TRIM_C;
         keep_a_q     <= 1'b0;
         keep_b_q     <= 1'b0;
         rdata_q      <= READ_ZERO;
      end
      else
      begin
         state_q      <= state_d;
         vco_coarse_q <= vco_coarse_d;
         cal_ctrl_q   <= cal_ctrl_d;
         rc_hi_q      <= rc_hi_d;
         rc_lo_q      <= rc_lo_d;
         synth_test_q <= synth_test_d;
         prod_trim_q  <= prod_trim_d;
         gain_test_q  <= gain_test_d;
         trim_a_q     <= trim_a_d;
         trim_b_q     <= trim_b_d;
         trim_c_q     <= trim_c_d;
         keep_a_q     <= keep_a_d;
         keep_b_q     <= keep_b_d;
         rdata_q      <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs to the analog side
   // ----------------------------------------------------------------
   assign reg_rdata                     = rdata_q;
   assign cfg_out.vco_coarse_cal        = vco_coarse_q;
   assign cfg_out.synth_cal_ctrl        = cal_ctrl_q;
   assign cfg_out.rc_osc_cfg_hi         = rc_hi_q;
   assign cfg_out.rc_osc_cfg_lo         = rc_lo_q;
   assign cfg_out.synth_test            = synth_test_q;
   assign cfg_out.production_trim       = prod_trim_q;
   assign cfg_out.gain_ctrl_test        = gain_test_q;
   assign cfg_out.analog_trim_a         = keep_a_q ? KEEP_ANALOG_TRIM_A : trim_a_q;
   assign cfg_out.analog_trim_b         = keep_b_q ? KEEP_ANALOG_TRIM_B : trim_b_q;
   assign cfg_out.analog_trim_c         = trim_c_q;
   assign cfg_out.vco_select_cal_enable = trim_c_q[VCO_SEL_CAL_BIT];

endmodule

/* File: tb/sctrb_reg_bank_props.sv */
`timescale 1ns/1ns
// ------------------------------------------
// register bank checker
// ------------------------------------------
module sctrb_reg_bank_props
#(
   parameter int ADDR_W = 6
)
(
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic [ADDR_W-1:0]     reg_addr,
   input wire logic                  reg_wr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  sleep_mode,
   input wire logic                  converter_keep_setting,
   input wire sctrb_pkg::sctrb_cfg_t cfg_out
);
   import sctrb_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // field widths and accepted writes
   unused_zero_a: assert property (
      {cfg_out.vco_coarse_cal[7:6], cfg_out.synth_cal_ctrl[7],
       cfg_out.rc_osc_cfg_hi[7], cfg_out.rc_osc_cfg_lo[7]} == 5'h00)
      else $error("unused bit set");
   coarse_write_a: assert property (
      reg_wr && !sleep_mode && !$past(sleep_mode) && reg_addr == ADDR_VCO_COARSE_CAL
      |=> cfg_out.vco_coarse_cal == ($past(reg_wdata) & MASK_6BIT)) else $error("coarse write lost");
   ctrl_write_a: assert property (
      reg_wr && !sleep_mode && !$past(sleep_mode) && reg_addr == ADDR_SYNTH_CAL_CTRL
      |=> cfg_out.synth_cal_ctrl == ($past(reg_wdata) & MASK_7BIT)) else $error("ctrl write lost");
   osc_read_a: assert property (
      reg_rd && reg_addr == ADDR_RC_OSC_CFG_HI |=> reg_rdata == $past(cfg_out.rc_osc_cfg_hi))
      else $error("osc readback");
   unmapped_rd_a: assert property (
      reg_rd && (reg_addr < 6'h25 || reg_addr > 6'h2E) |=> reg_rdata == READ_ZERO) else $error("unmapped read");
   // sleep keeps low registers and returns volatile ones to their defaults
   sleep_keep_a: assert property (
      sleep_mode |=> $stable(cfg_out.vco_coarse_cal) && $stable(cfg_out.synth_cal_ctrl)
      && $stable(cfg_out.rc_osc_cfg_hi) && $stable(cfg_out.rc_osc_cfg_lo)) else $error("kept reg changed");
   sleep_lose_a: assert property (
      sleep_mode && $past(sleep_mode) && !$past(rst) |=> cfg_out.synth_test == RST_SYNTH_TEST
      && cfg_out.production_trim == RST_PRODUCTION_TRIM && cfg_out.gain_ctrl_test == RST_GAIN_CTRL_TEST
      && cfg_out.analog_trim_c == RST_ANALOG_TRIM_C)
      else $error("volatile reg kept");
   // wake forcing and readback
   wake_force_a: assert property (
      !sleep_mode && $past(sleep_mode) && !$past(rst) |=> cfg_out.analog_trim_a ==
      ($past(converter_keep_setting) ? KEEP_ANALOG_TRIM_A : RST_ANALOG_TRIM_A) && cfg_out.analog_trim_b ==
      ($past(converter_keep_setting) ? KEEP_ANALOG_TRIM_B : RST_ANALOG_TRIM_B)) else $error("wake force");
   wake_read_a: assert property (
      (!sleep_mode && $past(sleep_mode) && !$past(rst)) ##1 (reg_rd && (reg_addr == ADDR_ANALOG_TRIM_A
      || reg_addr == ADDR_ANALOG_TRIM_B)) |=> reg_rdata == ($past(reg_addr) == ADDR_ANALOG_TRIM_A ?
      RST_ANALOG_TRIM_A : RST_ANALOG_TRIM_B)) else $error("wake readback");
   vco_sel_a: assert property (
      reg_wr && !sleep_mode && !$past(sleep_mode) && reg_addr == ADDR_ANALOG_TRIM_C
      |=> cfg_out.vco_select_cal_enable == $past(reg_wdata[VCO_SEL_CAL_BIT])) else $error("vco select");
endmodule

bind sctrb_reg_bank sctrb_reg_bank_props #(.ADDR_W(ADDR_W)) i_props (.sys_clk(sys_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sleep_mode(sleep_mode), .converter_keep_setting(converter_keep_setting), .cfg_out(cfg_out));

/* File: tb/sctrb_host_model.sv */
`timescale 1ns/1ns
// ------------------------------------------
// host side of the register port
// ------------------------------------------
module sctrb_host_model
(
   input  wire logic       sys_clk,
   output logic      [5:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   import sctrb_pkg::*;
   // idle port
   initial
   begin
      {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   end
   // one write; test-only registers are never written
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      if (a == ADDR_SYNTH_TEST || a == ADDR_GAIN_CTRL_TEST)
         return;
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
   endtask
   // one read, data taken a cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk);
      {reg_addr, reg_rd} <= {~a, 1'b0};
      #1 d = reg_rdata;
   endtask
   // temperature sensor on, default back before leaving idle
   task automatic temp_sense(input logic on);
      wr(ADDR_PRODUCTION_TRIM, on ? 8'hBF : RST_PRODUCTION_TRIM);
   endtask
   // channel hop restores a saved calibration result
   task automatic hop(input logic [7:0] saved);
      wr(ADDR_VCO_COARSE_CAL, saved);
   endtask
endmodule

/* File: tb/sctrb_reg_bank_tb.sv */
`timescale 1ns/1ns
module sctrb_reg_bank_tb;
   import sctrb_pkg::*;
   logic       sys_clk;
   logic       rst;
   logic [5:0] reg_addr;
   logic       reg_wr;
   logic [7:0] reg_wdata;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       sleep_mode;
   logic       converter_keep_setting;
   sctrb_cfg_t cfg_out;
   int         err_total;
   int         n_tests;
   int         seed;
   logic [7:0] got;
   logic [7:0] d;
   localparam logic [7:0] RST_TAB [10] = '{RST_VCO_COARSE_CAL, RST_SYNTH_CAL_CTRL, RST_RC_OSC_CFG_HI,
      RST_RC_OSC_CFG_LO, RST_SYNTH_TEST, RST_PRODUCTION_TRIM, RST_GAIN_CTRL_TEST, RST_ANALOG_TRIM_A,
      RST_ANALOG_TRIM_B, RST_ANALOG_TRIM_C};
   localparam logic [5:0] WR_ADDR [7] = '{6'h25, 6'h26, 6'h27, 6'h28, 6'h2C, 6'h2D, 6'h2E};

   sctrb_reg_bank #(.ADDR_W(6)) i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
      .converter_keep_setting(converter_keep_setting), .cfg_out(cfg_out));
   sctrb_host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   // writable bits of each register
   function automatic logic [7:0] mask_of(input logic [5:0] a);
      return (a == ADDR_VCO_COARSE_CAL) ? MASK_6BIT : (a < ADDR_SYNTH_TEST) ? MASK_7BIT : MASK_8BIT;
   endfunction
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      test_done;
   end
   initial
   begin
      {rst, sleep_mode, converter_keep_setting, seed, err_total, n_tests} = {1'b1, 2'b00, 32'd99, 64'd0};
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values, unmapped neighbours read zero
      for (int i = 0; i < 12; i++)
      begin
         i_host.rd(6'h24 + 6'(i), got);
         chk8(got, (i == 0 || i == 11) ? READ_ZERO : RST_TAB[i-1]);
      end
      $display("test reset values done");
      // random writes with all-ones and zero corners
      for (int i = 0; i < 28; i++)
      begin
         d = (i < 7) ? 8'hFF : (i < 14) ? 8'h00 : 8'($random(seed));
         i_host.wr(WR_ADDR[i%7], d);
         i_host.rd(WR_ADDR[i%7], got);
         chk8(got, d & mask_of(WR_ADDR[i%7]));
      end
      i_host.hop(8'h11);
      i_host.rd(ADDR_VCO_COARSE_CAL, got);
      chk8(got, 8'h11);
      $display("test read write done");
      i_host.temp_sense(1'b1);
      i_host.rd(ADDR_PRODUCTION_TRIM, got);
      chk8(got, 8'hBF);
      i_host.temp_sense(1'b0);
      i_host.rd(ADDR_PRODUCTION_TRIM, got);
      chk8(got, RST_PRODUCTION_TRIM);
      $display("test temperature done");
      // sleep with both converter settings, write refused in sleep
      for (int k = 0; k < 2; k++)
      begin
         i_host.wr(ADDR_VCO_COARSE_CAL, 8'h15 + 8'(k));
         i_host.wr(ADDR_ANALOG_TRIM_C, 8'h00);
         #1 chk8({7'h00, cfg_out.vco_select_cal_enable}, 8'h00);
         // sleep request launched on a rising edge
         @(posedge sys_clk);
         sleep_mode <= 1'b1;
         converter_keep_setting <= k[0];
         i_host.wr(ADDR_VCO_COARSE_CAL, 8'h3A);
         repeat (4) @(posedge sys_clk);
         sleep_mode <= 1'b0;
         i_host.rd(ADDR_ANALOG_TRIM_A, got);
         chk8(got, RST_ANALOG_TRIM_A);
         chk8(cfg_out.analog_trim_a, k ? KEEP_ANALOG_TRIM_A : RST_ANALOG_TRIM_A);
         chk8(cfg_out.analog_trim_b, k ? KEEP_ANALOG_TRIM_B : RST_ANALOG_TRIM_B);
         i_host.rd(ADDR_ANALOG_TRIM_B, got);
         chk8(got, RST_ANALOG_TRIM_B);
         i_host.rd(ADDR_ANALOG_TRIM_C, got);
         chk8(got, RST_ANALOG_TRIM_C);
         chk8({7'h00, cfg_out.vco_select_cal_enable}, 8'h01);
         i_host.rd(ADDR_VCO_COARSE_CAL, got);
         chk8(got, 8'h15 + 8'(k));
         i_host.wr(ADDR_ANALOG_TRIM_A, 8'h12);
         #1 chk8(cfg_out.analog_trim_a, 8'h12);
      end
      $display("test sleep done");
      test_done;
   end
endmodule
